// ==== bench/testbench.sv ====
// Self-checking bench for the serial port in its second-port role
`timescale 1ns/100ps
module testbench;
	typedef struct packed {
		logic [4:0] csel;
		logic [7:0] mode;
		logic [7:0] tx;
		logic [7:0] ptx;
		logic [7:0] shift;
		logic [7:0] prx;
		logic [7:0] cycles;
	} tws_row_s;
	localparam logic [15:0] BASE = tws_pkg::ADDR_MODE_PORT1;
	localparam logic [15:0] TXB = BASE + tws_pkg::OFS_TX_BUF;
	localparam logic [15:0] SHR = BASE + tws_pkg::OFS_SHIFT;
	localparam logic [15:0] CKR = BASE + tws_pkg::OFS_CLK_SEL;
	// ------------------------------------------------------------
	// Ordinary transfers: master at two rates, receive-only, slave, types 1 and 2
	// ------------------------------------------------------------
	// bit 5 stays clear in every row's mode
	tws_row_s rows [8] = '{
		'{5'h02, 8'hc0, 8'ha5, 8'h3c, 8'h3c, 8'ha5, 8'h40},
		'{5'h02, 8'hd0, 8'h01, 8'h1e, 8'h78, 8'h80, 8'h40},
		'{5'h0a, 8'hc0, 8'h69, 8'hc3, 8'hc3, 8'h69, 8'h40},
		'{5'h02, 8'h80, 8'h00, 8'h96, 8'h96, 8'h00, 8'h40},
		'{5'h03, 8'hc0, 8'h3c, 8'ha5, 8'ha5, 8'h3c, 8'h80},
		'{5'h0f, 8'hc0, 8'h3c, 8'h5a, 8'h5a, 8'h3c, 8'h00},
		'{5'h07, 8'hc0, 8'h5a, 8'hc3, 8'hc3, 8'h5a, 8'h00},
		'{5'h07, 8'hd0, 8'h01, 8'h1e, 8'h78, 8'h80, 8'h00}};
	logic [15:0] ofs [5] = '{16'h0000, 16'h0001, 16'h0004, 16'h0005, 16'h0002};
	logic core_clk, sys_rst, cpu_wr, cpu_rd, link_sck, sck_o, sck_oe;
	logic serial_in, serial_out, slave_select_n, busy, xfer_done, go, early;
	logic [15:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, peer_tx, peer_rx;
	int errors, samples_checked, lows;

	tws_port #(.SECOND_PORT(1'b1)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .link_sck(link_sck), .sck_o(sck_o), .sck_oe(sck_oe),
		.serial_in(serial_in), .serial_out(serial_out), .slave_select_n(slave_select_n),
		.busy(busy), .xfer_done(xfer_done));
	tws_peer peer_u (.sck_o(sck_o), .sck_oe(sck_oe), .serial_out(serial_out), .go(go),
		.early(early), .peer_tx(peer_tx), .link_sck(link_sck), .serial_in(serial_in),
		.peer_rx(peer_rx));

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	task automatic report_and_stop();
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// A leading idle edge keeps strobes from being set twice in one step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge core_clk);
		cpu_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge core_clk);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge core_clk);
		cpu_rd = 1'b0;
		d = cpu_rdata;
	endtask
	task automatic kick();
		go = 1'b1;
		@(negedge core_clk);
		go = 1'b0;
	endtask
	// Count busy cycles; a slave frame is launched once the link is armed
	task automatic run(input bit ro, input bit slv, output int n);
		int k;
		n = 0;
		k = 0;
		while (busy !== 1'b1 && k < 4) begin
			@(negedge core_clk);
			k++;
		end
		if (slv) begin
			repeat (3) @(negedge core_clk);
			kick();
		end
		while (busy === 1'b1 && n < 1000) begin
			if (ro && serial_out !== 1'b0)
				lows++;
			@(negedge core_clk);
			n++;
		end
	endtask

	initial begin
		#2000000;
		errors++;
		report_and_stop();
	end

	initial begin
		logic [7:0] d;
		int n;
		sys_rst = 1'b1;
		cpu_addr = 16'h0000;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_wdata = 8'h00;
		slave_select_n = 1'b1;
		go = 1'b0;
		early = 1'b0;
		peer_tx = 8'h00;
		errors = 0;
		samples_checked = 0;
		lows = 0;
		repeat (8) @(negedge core_clk);
		sys_rst = 1'b0;
		chk({3'h0, sck_o, busy, sck_oe, serial_out, xfer_done}, 8'h10);
		wr(BASE + 16'h0002, 8'hff);
		for (int i = 0; i < 5; i++) begin
			rd(BASE + ofs[i], d);
			chk(d, 8'h00);
		end
		for (int r = 0; r < 8; r++) begin
			wr(BASE, 8'h00);
			wr(CKR, {3'h0, rows[r].csel});
			wr(BASE, rows[r].mode);
			peer_tx = rows[r].ptx;
			early = rows[r].csel[tws_pkg::CLK_DAP_BIT];
			if (rows[r].csel[2:0] != tws_pkg::CKS_EXTERNAL)
				kick();
			if (rows[r].mode[6])
				wr(TXB, rows[r].tx);
			else
				rd(SHR, d);
			// Buffers and mode bits are left alone until busy drops
			run(!rows[r].mode[6], rows[r].csel[2:0] == tws_pkg::CKS_EXTERNAL, n);
			chk({7'h00, xfer_done}, 8'h01);
			if (rows[r].cycles != 8'h00)
				chk(n[7:0], rows[r].cycles);
			rd(SHR, d);
			chk(d, rows[r].shift);
			chk(peer_rx, rows[r].prx);
		end
		chk(lows[7:0], 8'h00);
		// Abort a running transfer by clearing the enable bit
		wr(BASE, 8'h00);
		wr(CKR, 8'h03);
		wr(BASE, 8'hc0);
		kick();
		wr(TXB, 8'h77);
		repeat (10) @(negedge core_clk);
		rd(BASE, d);
		chk(d, 8'hc1);
		wr(BASE, 8'h40);
		chk({7'h00, busy}, 8'h00);
		rd(SHR, d);
		chk(d, 8'h00);
		// Select input in use: refused while high, accepted while low
		wr(CKR, 8'h07);
		wr(BASE, 8'he0);
		wr(TXB, 8'h33);
		repeat (3) @(negedge core_clk);
		chk({7'h00, busy}, 8'h00);
		wr(BASE, 8'ha0);
		rd(SHR, d);
		repeat (3) @(negedge core_clk);
		chk({7'h00, busy}, 8'h00);
		slave_select_n = 1'b0;
		repeat (3) @(negedge core_clk);
		peer_tx = 8'h81;
		rd(SHR, d);
		run(1'b1, 1'b1, n);
		rd(SHR, d);
		chk(d, 8'h81);
		// Reset after the frame has ended clears buffer, shifter and mode
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		chk({7'h00, busy}, 8'h00);
		rd(TXB, d);
		chk(d, 8'h00);
		rd(SHR, d);
		chk(d, 8'h00);
		rd(BASE, d);
		chk(d, 8'h00);
		// Polarity bit alone moves the idle clock level low
		wr(CKR, 8'h10);
		chk({7'h00, sck_o}, 8'h00);
		report_and_stop();
	end
endmodule

// ==== bench/tws_peer.sv ====
// Peripheral partner model on the far side of the serial port
`timescale 1ns/100ps
module tws_peer (
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic serial_out,
	input wire logic go,
	input wire logic early,
	input wire logic [7:0] peer_tx,
	output logic link_sck,
	output logic serial_in,
	output logic [7:0] peer_rx
);
	int idx = 8;
	initial begin
		link_sck = 1'b1;
		serial_in = 1'b0;
		peer_rx = 8'h00;
	end
	// Slave role: sample on the rising clock, or the falling one for early-phase types
	// Outside a frame the data line shows the inverse of its last bit
	always @(sck_o) begin
		if (sck_oe && idx < 8 && sck_o != early) begin
			peer_rx = {peer_rx[6:0], serial_out};
			idx = idx + 1;
			serial_in = (idx < 8) ? peer_tx[7 - idx] : ~serial_in;
		end
	end
	// Master role: eight clocks of 32 ns, standing high between frames
	always @(posedge go) begin
		idx = 0;
		peer_rx = 8'h00;
		serial_in = peer_tx[7];
		if (!sck_oe) begin
			for (int i = 0; i < 8; i++) begin
				#16 link_sck = 1'b0;
				if (early)
					peer_rx = {peer_rx[6:0], serial_out};
				else
					serial_in = peer_tx[7 - i];
				#16 link_sck = 1'b1;
				if (early)
					serial_in = (i < 7) ? peer_tx[6 - i] : ~serial_in;
				else
					peer_rx = {peer_rx[6:0], serial_out};
			end
			idx = 8;
			if (!early)
				#16 serial_in = ~serial_in;
		end
	end
endmodule

// ==== src/tws_pkg.sv ====
// Constants and carrier types for the three-wire clocked serial port
package tws_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE_PORT0 = 16'hff80;
	localparam logic [15:0] ADDR_MODE_PORT1 = 16'hff88;
	localparam logic [15:0] OFS_CLK_SEL = 16'h0001;
	localparam logic [15:0] OFS_TX_BUF = 16'h0004;
	localparam logic [15:0] OFS_SHIFT = 16'h0005;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_TRMD_BIT = 6;
	localparam int MODE_SSE_BIT = 5;
	localparam int MODE_DIR_BIT = 4;
	localparam int MODE_BUSY_BIT = 0;
	localparam int CLK_CKP_BIT = 4;
	localparam int CLK_DAP_BIT = 3;
	localparam int CLK_CKS_LSB = 0;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CLK_SEL = 8'h00;
	localparam logic [7:0] RST_TX_BUF = 8'h00;
	localparam logic [7:0] RST_SHIFT = 8'h00;
	localparam logic [2:0] CKS_EXTERNAL = 3'h7;
	localparam int WORD_BITS = 8;
	localparam logic [3:0] PHASES_LAST = 4'hf;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MASTER = 3'b010,
		ST_SLAVE = 3'b100
	} tws_state_e;

	typedef struct packed {
		logic en;
		logic trmd;
		logic sse;
		logic dir;
	} tws_mode_s;

	typedef struct packed {
		logic ckp;
		logic dap;
		logic [2:0] cks;
	} tws_clk_s;

endpackage

// ==== src/tws_port.sv ====
// Three-wire clocked serial port with CPU register access
`timescale 1ns/100ps

// What this block does
// - Two modes only: stopped, or three-wire clocked serial operation.
// - Exchanges 8-bit words over clock, serial in and serial out lines.
// - Shifts out and samples in during the same transfer.
// - Bit-order bit 4: 0 sends MSB first, 1 sends LSB first.
// - Transmit buffer write starts transfer when enable and direction bits are 1.
// - Written byte is loaded into shift register and serialized onto output.
// - Reset clears transmit buffer and shift register to 00.
// - With direction bit 0, reading the shift register starts receive-only transfer.
// - Each received bit is sampled from serial input into shift register.
// - Direction 0 is receive-only, direction 1 is transmit and receive.
// - Serial output held low while direction bit is 0.
// - Clearing enable stops and resets busy flag and shift register asynchronously.
// - Busy flag reads 1 during a transfer, 0 when stopped.
// - Second port only: select-use bit 5 decides whether select input matters.
// - Slave with select used: buffer write starts only while select is low.
// - Slave with select used: shift read starts reception only while select low.
// - Mode register resets to 00, port disabled.
// - Clock select picks core clock divided 2 to 128, or 111 external.
// - Polarity and phase bits choose one of four types, type 1 after reset.
module tws_port #(
	parameter bit SECOND_PORT = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	input wire logic link_sck,
	output logic sck_o,
	output logic sck_oe,
	input wire logic serial_in,
	output logic serial_out,
	input wire logic slave_select_n,
	output logic busy,
	output logic xfer_done
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
		input logic lsb_first);
		shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
	endfunction

	function automatic logic pick_bit(input logic [7:0] d, input logic [2:0] k,
		input logic lsb_first);
		pick_bit = lsb_first ? d[k] : d[3'h7 - k];
	endfunction

	localparam logic [15:0] BASE = SECOND_PORT ? tws_pkg::ADDR_MODE_PORT1 :
		tws_pkg::ADDR_MODE_PORT0;

	tws_pkg::tws_mode_s mode_q;
	tws_pkg::tws_clk_s clk_q;
	tws_pkg::tws_state_e state_q;
	logic [7:0] tx_buf_q;
	logic [7:0] shift_q;
	logic [7:0] cpu_rdata_q;
	logic [3:0] ph_q;
	logic [6:0] div_q;
	logic so_q;
	logic arm_q;
	logic done_q;
	logic done_seen_q;
	logic [1:0] si_sync_q;
	logic [1:0] ss_sync_q;
	logic [1:0] done_sync_q;
	logic int_rst;
	logic is_master;
	logic sel_ok;
	logic start_tx;
	logic start_rx;
	logic slave_done;
	logic [6:0] half_last;
	logic idle_lvl;
	logic [7:0] lrx_q;
	logic [3:0] lcnt_q;
	logic [3:0] ldrv_q;
	logic ldone_q;
	logic lrst;
	logic samp_clk;
	logic [3:0] sidx;

	// ------------------------------------------------------------
	// Decode and start conditions
	// ------------------------------------------------------------
	// enable low holds the engine in reset
	assign int_rst = sys_rst | ~mode_q.en;
	assign is_master = clk_q.cks != tws_pkg::CKS_EXTERNAL;
	assign half_last = 7'((7'd1 << clk_q.cks) - 7'd1);
	assign idle_lvl = ~clk_q.ckp;
	// select input matters only on the second port with its bit set
	assign sel_ok = !(SECOND_PORT && mode_q.sse && !is_master) || !ss_sync_q[1];
	// write starts a full duplex transfer
	assign start_tx = cpu_wr && cpu_addr == BASE + tws_pkg::OFS_TX_BUF && mode_q.en &&
		mode_q.trmd && state_q == tws_pkg::ST_IDLE && sel_ok;
	assign start_rx = cpu_rd && cpu_addr == BASE + tws_pkg::OFS_SHIFT && mode_q.en &&
		!mode_q.trmd && state_q == tws_pkg::ST_IDLE && sel_ok;
	assign slave_done = done_sync_q[1] && !done_seen_q;
	assign busy = state_q != tws_pkg::ST_IDLE;
	assign xfer_done = done_q;
	assign cpu_rdata = cpu_rdata_q;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			si_sync_q <= 2'h0;
			ss_sync_q <= 2'h3;
			done_sync_q <= 2'h0;
		end else begin
			si_sync_q <= {si_sync_q[0], serial_in};
			ss_sync_q <= {ss_sync_q[0], slave_select_n};
			done_sync_q <= {done_sync_q[0], ldone_q};
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// mode and clock select clear to zero, type 1
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= tws_pkg::tws_mode_s'(tws_pkg::RST_MODE[7:4]);
			clk_q <= tws_pkg::tws_clk_s'(tws_pkg::RST_CLK_SEL[4:0]);
		end else if (cpu_wr && cpu_addr == BASE) begin
			mode_q.en <= cpu_wdata[tws_pkg::MODE_EN_BIT];
			mode_q.trmd <= cpu_wdata[tws_pkg::MODE_TRMD_BIT];
			mode_q.sse <= SECOND_PORT & cpu_wdata[tws_pkg::MODE_SSE_BIT];
			mode_q.dir <= cpu_wdata[tws_pkg::MODE_DIR_BIT];
		end else if (cpu_wr && cpu_addr == BASE + tws_pkg::OFS_CLK_SEL) begin
			clk_q.ckp <= cpu_wdata[tws_pkg::CLK_CKP_BIT];
			clk_q.dap <= cpu_wdata[tws_pkg::CLK_DAP_BIT];
			clk_q.cks <= cpu_wdata[tws_pkg::CLK_CKS_LSB +: 3];
		end
	end

	// buffer clears on system reset only
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_buf_q <= tws_pkg::RST_TX_BUF;
		end else if (cpu_wr && cpu_addr == BASE + tws_pkg::OFS_TX_BUF) begin
			tx_buf_q <= cpu_wdata;
		end
	end

	// Read data lands one cycle after the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_rdata_q <= 8'h00;
		end else if (cpu_rd) begin
			if (cpu_addr == BASE) begin
				cpu_rdata_q <= {mode_q.en, mode_q.trmd, mode_q.sse, mode_q.dir, 3'h0, busy};
			end else if (cpu_addr == BASE + tws_pkg::OFS_CLK_SEL) begin
				cpu_rdata_q <= {3'h0, clk_q.ckp, clk_q.dap, clk_q.cks};
			end else if (cpu_addr == BASE + tws_pkg::OFS_TX_BUF) begin
				cpu_rdata_q <= tx_buf_q;
			end else if (cpu_addr == BASE + tws_pkg::OFS_SHIFT) begin
				cpu_rdata_q <= shift_q;
			end else begin
				cpu_rdata_q <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer engine
	// ------------------------------------------------------------
	// engine runs only while enabled
	always_ff @(posedge core_clk or posedge int_rst) begin
		if (int_rst) begin
			state_q <= tws_pkg::ST_IDLE;
			ph_q <= 4'h0;
			div_q <= 7'h00;
			arm_q <= 1'b0;
			done_q <= 1'b0;
			done_seen_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			done_seen_q <= done_sync_q[1];
			unique case (state_q)
				tws_pkg::ST_IDLE: begin
					if (start_tx || start_rx) begin
						ph_q <= 4'h0;
						div_q <= half_last;
						arm_q <= !is_master;
						state_q <= is_master ? tws_pkg::ST_MASTER : tws_pkg::ST_SLAVE;
					end
				end
				tws_pkg::ST_MASTER: begin
					// each clock half lasts 2^cks core cycles
					if (div_q == 7'h00) begin
						div_q <= half_last;
						ph_q <= ph_q + 4'h1;
						if (ph_q == tws_pkg::PHASES_LAST) begin
							state_q <= tws_pkg::ST_IDLE;
							done_q <= 1'b1;
						end
					end else begin
						div_q <= div_q - 7'h01;
					end
				end
				tws_pkg::ST_SLAVE: begin
					if (slave_done) begin
						arm_q <= 1'b0;
						state_q <= tws_pkg::ST_IDLE;
						done_q <= 1'b1;
					end
				end
				default: state_q <= tws_pkg::ST_IDLE;
			endcase
		end
	end

	// shift register also clears when enable drops
	always_ff @(posedge core_clk or posedge int_rst) begin
		if (int_rst) begin
			shift_q <= tws_pkg::RST_SHIFT;
		end else if (start_tx) begin
			// written byte goes straight into the shifter
			shift_q <= cpu_wdata;
		end else if (state_q == tws_pkg::ST_MASTER && div_q == 7'h00 && !ph_q[0]) begin
			// sample at the start of each odd half
			shift_q <= shift_in(shift_q, si_sync_q[1], mode_q.dir);
		end else if (state_q == tws_pkg::ST_SLAVE && slave_done) begin
			shift_q <= lrx_q;
		end
	end

	// next output bit is taken from the end chosen by bit order
	always_ff @(posedge core_clk or posedge int_rst) begin
		if (int_rst) begin
			so_q <= 1'b0;
		end else if (start_tx) begin
			so_q <= mode_q.dir ? cpu_wdata[0] : cpu_wdata[7];
		end else if (state_q == tws_pkg::ST_MASTER && div_q == 7'h00 && ph_q[0] &&
			ph_q != tws_pkg::PHASES_LAST) begin
			so_q <= mode_q.dir ? shift_q[0] : shift_q[7];
		end
	end

	// ------------------------------------------------------------
	// Link clock domain for slave mode
	// ------------------------------------------------------------
	// Config is static while busy, so inverting the clock here cannot glitch
	assign samp_clk = link_sck ^ (clk_q.ckp ^ clk_q.dap);
	// Armed level from the core acts as the link reset; the link clock may be still
	assign lrst = int_rst | ~arm_q;

	always_ff @(posedge samp_clk or posedge lrst) begin
		if (lrst) begin
			lrx_q <= 8'h00;
			lcnt_q <= 4'h0;
			ldone_q <= 1'b0;
		end else if (lcnt_q != 4'(tws_pkg::WORD_BITS)) begin
			// slave samples the input on the link clock itself
			lrx_q <= shift_in(lrx_q, serial_in, mode_q.dir);
			lcnt_q <= lcnt_q + 4'h1;
			ldone_q <= lcnt_q == 4'(tws_pkg::WORD_BITS - 1);
		end
	end

	always_ff @(negedge samp_clk or posedge lrst) begin
		if (lrst) begin
			ldrv_q <= 4'h0;
		end else if (ldrv_q != 4'(tws_pkg::WORD_BITS)) begin
			ldrv_q <= ldrv_q + 4'h1;
		end
	end

	// Early-phase types show bit 0 before the first edge
	assign sidx = (clk_q.dap || ldrv_q == 4'h0) ? ldrv_q : ldrv_q - 4'h1;

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	// output parked low in receive-only mode
	always_comb begin
		if (!mode_q.trmd) begin
			serial_out = 1'b0;
		end else if (state_q == tws_pkg::ST_SLAVE) begin
			serial_out = pick_bit(tx_buf_q, sidx[2:0], mode_q.dir);
		end else begin
			serial_out = so_q;
		end
	end

	// clock level follows polarity and phase type
	assign sck_o = (state_q == tws_pkg::ST_MASTER) ?
		idle_lvl ^ (clk_q.dap ? ph_q[0] : ~ph_q[0]) : idle_lvl;
	assign sck_oe = mode_q.en && is_master;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	tx_start_a: assert property (start_tx |=> busy)
		else $error("transmit write did not start a transfer");
	rx_start_a: assert property (start_rx |=> busy && !mode_q.trmd)
		else $error("shift read did not start reception");
	rxonly_low_a: assert property (!mode_q.trmd |-> !serial_out)
		else $error("serial output not low in receive mode");
	disable_clear_a: assert property (!mode_q.en |-> !busy && shift_q == 8'h00)
		else $error("disabled port still busy or holds data");
	select_block_a: assert property (cpu_wr && cpu_addr == BASE + tws_pkg::OFS_TX_BUF &&
		!busy && mode_q.sse && !is_master && ss_sync_q[1] |=> !busy)
		else $error("transfer started with select high");
	// Clearing enable is a legal abort, so it ends the check early
	master_len_a: assert property (disable iff (sys_rst || !mode_q.en)
		$rose(busy) && is_master && clk_q.cks == 3'h2 |-> ##63 busy ##1 !busy)
		else $error("master transfer with four-cycle halves has wrong length");
	done_pulse_a: assert property ($fell(busy) && mode_q.en |-> xfer_done ##1 !xfer_done)
		else $error("completion pulse missing");
	sck_idle_a: assert property (!busy |-> sck_o == ~clk_q.ckp)
		else $error("serial clock not at idle level");
	div_half_a: assert property (disable iff (sys_rst || !mode_q.en)
		busy && is_master && clk_q.cks == 3'h2 && $changed(sck_o) |=> $stable(sck_o) [*3])
		else $error("clock half period too short");
	reset_vals_a: assert property ($past(sys_rst) |-> mode_q == 4'h0 && tx_buf_q == 8'h00)
		else $error("registers not cleared by reset");

	master_done_c: cover property ($fell(busy) && is_master && mode_q.trmd);
	slave_done_c: cover property ($fell(busy) && !is_master);
	rx_only_c: cover property (start_rx);
	lsb_first_c: cover property (start_tx && mode_q.dir);

endmodule
